// [hw/lfclk_cfg.svh]
/*
 * Constants for the line frequency clock: data bit positions and
 * timing figures.
 * Assumes inclusion by bare name from design files.
 */
`ifndef LFCLK_CFG_SVH
`define LFCLK_CFG_SVH

`define LFCLK_FLAG_BIT 7
`define LFCLK_ENAB_BIT 6
`define LFCLK_PERIOD60_US 16700
`define LFCLK_PERIOD50_US 20000
`define LFCLK_CLK_NS 8

`endif

// [hw/lfclk_pkg.sv]
/*
 * Types for the line frequency clock.
 * Assumes the cfg header is compiled alongside.
 */
package lfclk_pkg;

	typedef struct packed {
		logic writeSel;
		logic readSel;
		logic busBusy;
		logic [15:0] writeData;
	} lfclk_bus_t;

	typedef struct packed {
		logic [15:0] readData;
		logic readDrive;
	} lfclk_rd_t;

endpackage

// [hw/line_frequency_clock.sv]
/*
 * Line frequency clock: flag, enable, pending interrupt and request.
 * Assumes a processor clock whose enabled cycles are the clock pulse,
 * and an asynchronous mains sense input.
 */
`timescale 1ns/10ps
`include "lfclk_cfg.svh"

module line_frequency_clock (
	input wire logic clock,
	input wire logic nrst,
	input wire logic processorClockPulse,
	input wire logic lineSenseInput,
	input wire lfclk_pkg::lfclk_bus_t bus,
	input wire logic priorityBit7Inverted,
	input wire logic priorityBit6Inverted,
	input wire logic serviceAcknowledge,
	output lfclk_pkg::lfclk_rd_t rd,
	output logic lineIrqRequest
);

	logic senseMeta_q;
	logic senseSync_q;
	logic senseLast_q;
	logic senseRise;
	logic flag_q;
	logic irqEnableBit_q;
	logic linePendingBit_q;
	logic pendingSyncStage_q;
	logic flagClearStrobe;
	logic priorityOk;

	// two-stage synchroniser, edge from second stage only
	always_ff @(posedge clock) begin
		if (!nrst) begin
			senseMeta_q <= 1'b0;
			senseSync_q <= 1'b0;
			senseLast_q <= 1'b0;
		end else begin
			senseMeta_q <= lineSenseInput;
			senseSync_q <= senseMeta_q;
			senseLast_q <= senseSync_q;
		end
	end

	assign senseRise = senseSync_q & ~senseLast_q;

	assign flagClearStrobe = bus.writeSel & processorClockPulse &
		bus.writeData[`LFCLK_FLAG_BIT];

	// set wins over clear
	always_ff @(posedge clock) begin
		if (!nrst) begin
			flag_q <= 1'b0;
		end else if (senseRise) begin
			flag_q <= 1'b1;
		end else if (flagClearStrobe) begin
			flag_q <= 1'b0;
		end
	end

	always_ff @(posedge clock) begin
		if (!nrst) begin
			irqEnableBit_q <= 1'b0;
		end else if (bus.writeSel && processorClockPulse) begin
			irqEnableBit_q <= bus.writeData[`LFCLK_ENAB_BIT];
		end
	end

	always_ff @(posedge clock) begin
		if (!nrst) begin
			linePendingBit_q <= 1'b0;
		end else if (senseRise) begin
			linePendingBit_q <= 1'b1;
		end else if (serviceAcknowledge && processorClockPulse) begin
			linePendingBit_q <= 1'b0;
		end
	end

	always_ff @(posedge clock) begin
		if (!nrst) begin
			pendingSyncStage_q <= 1'b0;
		end else if (processorClockPulse) begin
			pendingSyncStage_q <= linePendingBit_q;
		end
	end

	assign priorityOk = priorityBit7Inverted | priorityBit6Inverted;
	assign lineIrqRequest = pendingSyncStage_q & irqEnableBit_q &
		priorityOk;

	// internal decode only; drive lines during select and bus busy
	always_comb begin
		rd.readDrive = bus.readSel & bus.busBusy;
		rd.readData = 16'h0000;
		if (rd.readDrive) begin
			rd.readData[`LFCLK_FLAG_BIT] = flag_q;
			rd.readData[`LFCLK_ENAB_BIT] = irqEnableBit_q;
		end
	end

	// flag: set by edge, held, cleared by write
	a_flag_sets: assert property (@(posedge clock)
		disable iff (!nrst) senseRise |=> flag_q)
		else $error("flag not set after sense edge");

	a_flag_holds: assert property (@(posedge clock)
		disable iff (!nrst) flag_q && !flagClearStrobe |=> flag_q)
		else $error("flag dropped without clear");

	a_flag_clears: assert property (@(posedge clock)
		disable iff (!nrst) flagClearStrobe && !senseRise |=> !flag_q)
		else $error("flag not cleared by write");

	a_flag_needs_pulse: assert property (@(posedge clock)
		disable iff (!nrst) flag_q && !processorClockPulse |=> flag_q)
		else $error("flag cleared between clock pulses");

	a_flag_rise_src: assert property (@(posedge clock)
		disable iff (!nrst) $rose(flag_q) |-> $past(senseRise))
		else $error("flag set without sense edge");

	// enable bit and read path
	a_enable_loads: assert property (@(posedge clock)
		disable iff (!nrst) bus.writeSel && processorClockPulse |=>
		irqEnableBit_q == $past(bus.writeData[`LFCLK_ENAB_BIT]))
		else $error("enable bit not loaded");

	a_enable_keeps: assert property (@(posedge clock)
		disable iff (!nrst) !(bus.writeSel && processorClockPulse) |=>
		$stable(irqEnableBit_q))
		else $error("enable bit changed without write");

	a_read_gated: assert property (@(posedge clock)
		disable iff (!nrst)
		!(bus.readSel && bus.busBusy) |-> rd.readData == 16'h0000)
		else $error("read lines driven outside read");

	a_drive_needs_busy: assert property (@(posedge clock)
		disable iff (!nrst)
		!(bus.readSel && bus.busBusy) |-> !rd.readDrive)
		else $error("read drive outside bus busy");

	a_read_bits: assert property (@(posedge clock)
		disable iff (!nrst) bus.readSel && bus.busBusy |->
		rd.readData[7] == flag_q && rd.readData[6] == irqEnableBit_q)
		else $error("read data mismatch");

	// request gating
	a_prio_blocks: assert property (@(posedge clock)
		disable iff (!nrst)
		!priorityBit7Inverted && !priorityBit6Inverted |-> !lineIrqRequest)
		else $error("request at priority 6 or 7");

	a_req_off_disabled: assert property (@(posedge clock)
		disable iff (!nrst) !irqEnableBit_q |-> !lineIrqRequest)
		else $error("request while enable bit clear");

	a_req_needs_sync: assert property (@(posedge clock)
		disable iff (!nrst) lineIrqRequest |-> pendingSyncStage_q)
		else $error("request without synchronised pending");

	a_edge_to_req: assert property (@(posedge clock)
		disable iff (!nrst) senseRise ##1 processorClockPulse ##1
		irqEnableBit_q && priorityOk |-> lineIrqRequest)
		else $error("request missing after pending");

	// pending bit and its sync stage
	a_pend_sets: assert property (@(posedge clock)
		disable iff (!nrst) senseRise |=> linePendingBit_q)
		else $error("pending not set after sense edge");

	a_pend_rise_src: assert property (@(posedge clock)
		disable iff (!nrst) $rose(linePendingBit_q) |-> $past(senseRise))
		else $error("pending set without sense edge");

	a_pend_holds: assert property (@(posedge clock)
		disable iff (!nrst)
		linePendingBit_q && !(serviceAcknowledge && processorClockPulse)
		|=> linePendingBit_q)
		else $error("pending dropped without service");

	a_ack_clears: assert property (@(posedge clock)
		disable iff (!nrst)
		serviceAcknowledge && processorClockPulse && !senseRise |=>
		!linePendingBit_q)
		else $error("pending not cleared by service");

	a_sync_follows: assert property (@(posedge clock)
		disable iff (!nrst) processorClockPulse |=>
		pendingSyncStage_q == $past(linePendingBit_q))
		else $error("sync stage missed the pending bit");

	a_sync_holds: assert property (@(posedge clock)
		disable iff (!nrst) !processorClockPulse |=>
		$stable(pendingSyncStage_q))
		else $error("sync stage moved between clock pulses");

	a_sync_rise_src: assert property (@(posedge clock)
		disable iff (!nrst)
		$rose(pendingSyncStage_q) |-> $past(linePendingBit_q))
		else $error("sync stage set without pending");

	a_sync_in: assert property (@(posedge clock)
		disable iff (!nrst)
		$rose(lineSenseInput) ##1 lineSenseInput ##1 lineSenseInput
		|-> senseRise)
		else $error("sense edge not detected");

	// main scenarios
	c_flag_set: cover property (@(posedge clock) disable iff (!nrst)
		senseRise ##1 flag_q);

	c_request: cover property (@(posedge clock) disable iff (!nrst)
		$rose(lineIrqRequest));

	c_serviced: cover property (@(posedge clock) disable iff (!nrst)
		lineIrqRequest ##1 serviceAcknowledge && processorClockPulse);

	c_flag_clear: cover property (@(posedge clock) disable iff (!nrst)
		flag_q ##1 flagClearStrobe ##1 !flag_q);

	c_blocked: cover property (@(posedge clock) disable iff (!nrst)
		pendingSyncStage_q && irqEnableBit_q && !priorityOk);

endmodule

// [sim/lfclk_mains_model.sv]
/* mains sense model: one square pulse per fire request.
 assumes the bench raises fire for one cycle per mains period. */
`timescale 1ns/10ps
module lfclk_mains_model #(parameter int HALF = 6) (
	input wire logic clock,
	input wire logic fire,
	output logic sense
);
	int n = 0;
	always @(posedge clock) begin
		if (fire && n == 0) n <= 2 * HALF;
		else if (n > 0) n <= n - 1;
	end
	assign sense = (n > HALF);
endmodule

// [sim/tb_line_frequency_clock.sv]
/* bench for the line frequency clock: queued notes, negedge watcher.
 assumes design and mains model compiled first. */
`timescale 1ns/10ps
module tb_line_frequency_clock;
	logic clock = 0, nrst = 0, pulse = 1, fire = 0, sense, smp = 0;
	logic p7 = 1, p6 = 1, ack = 0, irq;
	lfclk_pkg::lfclk_bus_t bus = '0;
	lfclk_pkg::lfclk_rd_t rd;
	logic [17:0] q[$];
	logic [15:0] w;
	int err_total = 0, checks_done = 0, cyc = 0, seed = 32'h6D71;
	always #4 clock = ~clock;
	lfclk_mains_model #(.HALF(6)) mains (.clock(clock), .fire(fire),
		.sense(sense));
	line_frequency_clock DUT (.clock(clock), .nrst(nrst),
		.processorClockPulse(pulse), .lineSenseInput(sense), .bus(bus),
		.priorityBit7Inverted(p7), .priorityBit6Inverted(p6),
		.serviceAcknowledge(ack), .rd(rd), .lineIrqRequest(irq));
	task automatic check(string nm, logic [17:0] s, logic [17:0] x);
		checks_done++;
		if (s !== x) begin
			err_total++;
			$display("[FAIL] %s expected %h seen %h", nm, x, s);
		end
	endtask
	task automatic final_report();
		$display("checks %0d mismatches %0d", checks_done, err_total);
		if (err_total == 0 && checks_done > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic wr(logic [15:0] d, logic p);
		@(posedge clock);
		bus.writeSel <= 1;
		bus.writeData <= d;
		pulse <= p;
		@(posedge clock);
		bus.writeSel <= 0;
		pulse <= 1;
	endtask
	task automatic rdk(logic f, logic e, logic i, logic b);
		@(posedge clock);
		bus.readSel <= 1;
		bus.busBusy <= b;
		q.push_back({8'h00, f & b, e & b, 6'h00, b, i});
		smp <= 1;
		@(posedge clock);
		smp <= 0;
		bus.readSel <= 0;
		bus.busBusy <= 0;
	endtask
	task automatic sense_pulse();
		@(posedge clock) fire <= 1;
		@(posedge clock) fire <= 0;
		repeat (20) @(posedge clock);
	endtask
	always @(negedge clock) begin
		if (smp) begin
			check("read word", {rd, irq}, q.pop_front());
		end
	end
	always @(posedge clock) begin
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			err_total++;
			final_report();
		end
	end
	initial begin
		repeat (20) @(posedge clock);
		nrst <= 1;
		rdk(0, 0, 0, 1);
		rdk(0, 0, 0, 0);
		wr(16'h0040, 0);
		rdk(0, 0, 0, 1);
		wr(16'h00C0, 1);
		rdk(0, 1, 0, 1);
		$display("register test done");
		sense_pulse();
		rdk(1, 1, 1, 1);
		wr(16'h0080, 0);
		rdk(1, 1, 1, 1);
		for (int pr = 0; pr < 8; pr++) begin
			@(posedge clock);
			p7 <= ~pr[2];
			p6 <= ~pr[1];
			rdk(1, 1, pr < 6, 1);
		end
		p7 <= 1;
		wr(16'h0040, 1);
		rdk(1, 1, 1, 1);
		@(posedge clock) ack <= 1;
		@(posedge clock) ack <= 0;
		repeat (3) @(posedge clock);
		rdk(1, 1, 0, 1);
		wr(16'h00C0, 1);
		rdk(0, 1, 0, 1);
		$display("interrupt test done");
		repeat (4) begin
			w = 16'($random(seed));
			wr(w & 16'hFF7F, 1);
			rdk(0, w[6], 0, 1);
		end
		wr(16'h0000, 1);
		sense_pulse();
		rdk(1, 0, 0, 1);
		wr(16'h0040, 1);
		rdk(1, 1, 1, 1);
		$display("pending test done");
		@(posedge clock) nrst <= 0;
		repeat (2) @(posedge clock);
		nrst <= 1;
		rdk(0, 0, 0, 1);
		$display("reset test done");
		final_report();
	end
endmodule
